// >>> heit_cfg.svh
/*
 * Offsets, field positions, reset values and limits of the host endpoint
 * interval and type block.
 * Assumes a 32-bit classic Wishbone slave decoding byte addresses.
 */
`ifndef HEIT_CFG_SVH
`define HEIT_CFG_SVH

// endpoint n owns the 16-byte slot at n * 0x10; slot 0 holds globals
`define HEIT_SLOT_MSB        7
`define HEIT_SLOT_LSB        4
`define HEIT_WORD_MSB        3
`define HEIT_WORD_LSB        2
`define HEIT_OFS_STATUS      2'h0
`define HEIT_OFS_MASK        2'h1
`define HEIT_OFS_INTERVAL    2'h0
`define HEIT_OFS_TXMODE      2'h1
`define HEIT_OFS_RXTYPE      2'h2

`define HEIT_SPEED_MSB       7
`define HEIT_SPEED_LSB       6
`define HEIT_TRANSFER_PROTOCOL_SELECT_MSB        5
`define HEIT_TRANSFER_PROTOCOL_SELECT_LSB        4
`define HEIT_EPNUM_MSB       3
`define HEIT_EPNUM_LSB       0

`define HEIT_RST_INTERVAL    8'h00
`define HEIT_RST_TYPE        8'h00
`define HEIT_RST_STATUS      16'h0000
`define HEIT_RST_MASK        16'h0000

`define HEIT_EXP_MAX         5'h10
`define HEIT_NAK_MIN         8'h02
`define HEIT_CNT_W           17

`endif

// >>> heit_pkg.sv
/*
 * Types shared by the host endpoint interval and type block.
 * Assumes heit_cfg.svh is on the include path.
 */
package heit_pkg;

    typedef enum logic [1:0] {
        HEIT_SPD_ILLEGAL = 2'h0,
        HEIT_SPD_HIGH    = 2'h1,
        HEIT_SPD_FULL    = 2'h2,
        HEIT_SPD_LOW     = 2'h3
    } heit_speed_e;

    typedef enum logic [1:0] {
        HEIT_TRANSFER_PROTOCOL_SELECT_CTRL = 2'h0,
        HEIT_TRANSFER_PROTOCOL_SELECT_ISO  = 2'h1,
        HEIT_TRANSFER_PROTOCOL_SELECT_BULK = 2'h2,
        HEIT_TRANSFER_PROTOCOL_SELECT_INTR = 2'h3
    } heit_transfer_protocol_select_e;

    // rx_endpoint_type and the tx mode register share this layout
    typedef struct packed {
        heit_speed_e speed;
        heit_transfer_protocol_select_e  transfer_protocol_select;
        logic [3:0]  target_rx_endpoint_number;
    } heit_type_s;

    // handshake report from the transaction engine
    typedef struct packed {
        logic       valid;
        logic [3:0] ep;
    } heit_evt_s;

    typedef enum logic [1:0] {
        HEIT_NAK_IDLE    = 2'h0,
        HEIT_NAK_STREAM  = 2'h1,
        HEIT_NAK_EXPIRED = 2'h3
    } heit_nak_e;

endpackage

// >>> heit_ep_sched.sv
/*
 * Per-endpoint scheduler: polling interval and bulk NAK timeout.
 * Assumes frame_tick pulses once per frame or microframe on clk_sys.
 */
`timescale 1ns/1ps
`include "heit_cfg.svh"

module heit_ep_sched (
    input  wire logic               clk_sys,
    input  wire logic               rst_b,
    input  wire logic [7:0]         interval_or_nak_limit,
    input  wire heit_pkg::heit_type_s tx_mode,
    input  wire logic               halt,
    input  wire logic               frame_tick,
    input  wire logic               nak_seen,
    input  wire logic               xfer_ok,
    output logic                    poll_r,
    output logic                    tmo_r
);
    import heit_pkg::*;

    localparam int CW = `HEIT_CNT_W;

    logic [CW-1:0] poll_cnt_r;
    logic [CW-1:0] poll_cnt_nxt;
    logic [CW-1:0] nak_cnt_r;
    logic [CW-1:0] nak_cnt_nxt;
    heit_nak_e     nak_st_r;
    heit_nak_e     nak_st_nxt;
    logic          poll_nxt;
    logic          tmo_nxt;
    logic [4:0]    m_clip;
    logic [CW-1:0] pow2;
    logic [CW-1:0] period;
    logic          is_hs;
    logic          is_intr;
    logic          is_iso;
    logic          poll_act;
    logic          nak_en;

    always_comb begin
        m_clip = (interval_or_nak_limit > 8'h10) ? `HEIT_EXP_MAX
                                                 : interval_or_nak_limit[4:0];
        pow2 = (m_clip == 5'h00) ? '0 : (CW'(1) << (m_clip - 5'h01));
        is_hs = tx_mode.speed == HEIT_SPD_HIGH;
        is_intr = tx_mode.transfer_protocol_select == HEIT_TRANSFER_PROTOCOL_SELECT_INTR;
        is_iso = tx_mode.transfer_protocol_select == HEIT_TRANSFER_PROTOCOL_SELECT_ISO;
        if (is_intr && !is_hs) begin
            period = CW'(interval_or_nak_limit);
        end else begin
            period = pow2;
        end
        poll_act = (is_intr || is_iso) && !halt && (period != '0)
                   && (tx_mode.speed != HEIT_SPD_ILLEGAL);
        nak_en = (tx_mode.transfer_protocol_select == HEIT_TRANSFER_PROTOCOL_SELECT_BULK)
                 && (interval_or_nak_limit >= `HEIT_NAK_MIN);
    end

    always_comb begin
        poll_nxt = 1'b0;
        poll_cnt_nxt = poll_cnt_r;
        if (!poll_act) begin
            poll_cnt_nxt = '0;
        end else if (frame_tick) begin
            if (poll_cnt_r + CW'(1) >= period) begin
                poll_nxt = 1'b1;
                poll_cnt_nxt = '0;
            end else begin
                poll_cnt_nxt = poll_cnt_r + CW'(1);
            end
        end
    end

    always_comb begin
        nak_st_nxt = nak_st_r;
        nak_cnt_nxt = nak_cnt_r;
        tmo_nxt = 1'b0;
        case (nak_st_r)
            HEIT_NAK_IDLE: begin
                nak_cnt_nxt = '0;
                if (nak_en && nak_seen && !halt) begin
                    nak_st_nxt = HEIT_NAK_STREAM;
                end
            end
            HEIT_NAK_STREAM: begin
                if (!nak_en || xfer_ok || halt) begin
                    nak_st_nxt = HEIT_NAK_IDLE;
                end else if (frame_tick) begin
                    nak_cnt_nxt = nak_cnt_r + CW'(1);
                    if (nak_cnt_r + CW'(1) > pow2) begin
                        tmo_nxt = 1'b1;
                        nak_st_nxt = HEIT_NAK_EXPIRED;
                    end
                end
            end
            HEIT_NAK_EXPIRED: begin
                if (!halt && !tmo_r) begin
                    nak_st_nxt = HEIT_NAK_IDLE;
                end
            end
            default: begin
                nak_st_nxt = HEIT_NAK_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            poll_cnt_r <= '0;
            nak_cnt_r <= '0;
            nak_st_r <= HEIT_NAK_IDLE;
            poll_r <= 1'b0;
            tmo_r <= 1'b0;
        end else begin
            poll_cnt_r <= poll_cnt_nxt;
            nak_cnt_r <= nak_cnt_nxt;
            nak_st_r <= nak_st_nxt;
            poll_r <= poll_nxt;
            tmo_r <= tmo_nxt;
        end
    end

    chk_poll_proto: assert property (@(posedge clk_sys) disable iff (!rst_b)
        poll_r |-> $past(poll_act))
        else $error("poll issued while endpoint not polled");
    chk_ls_interval: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (frame_tick && poll_act && is_intr && !is_hs
         && poll_cnt_r == CW'(interval_or_nak_limit) - CW'(1))
        |=> poll_r)
        else $error("low or full speed poll not every m frames");
    chk_hs_interval: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (frame_tick && poll_act && is_intr && is_hs
         && poll_cnt_r + CW'(1) == pow2) |=> poll_r)
        else $error("high speed poll not every 2^(m-1) microframes");
    chk_iso_interval: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (frame_tick && poll_act && is_iso && poll_cnt_r + CW'(1) < pow2)
        |=> !poll_r)
        else $error("isochronous poll came early");
    chk_nak_limit: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (nak_st_r == HEIT_NAK_STREAM && nak_en && !xfer_ok && !halt
         && frame_tick && nak_cnt_r == pow2) |=> tmo_r)
        else $error("nak limit passed without timeout");
    chk_nak_off: assert property (@(posedge clk_sys) disable iff (!rst_b)
        tmo_r |-> $past(nak_en))
        else $error("timeout while nak limit disabled");
    chk_nak_count: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (nak_st_r == HEIT_NAK_STREAM && nak_en && !xfer_ok && !halt
         && frame_tick) |=> nak_cnt_r == $past(nak_cnt_r) + CW'(1))
        else $error("nak frame count did not advance");

endmodule

// >>> heit_top.sv
/*
 * Host endpoint interval and type registers with their schedulers,
 * reached over a classic Wishbone slave port.
 * Assumes frame ticks and handshake reports come from logic on clk_sys.
 */
`timescale 1ns/1ps
`include "heit_cfg.svh"

module heit_top #(
    parameter int NUM_EP = 4
) (
    input  wire logic                    clk_sys,
    input  wire logic                    rst_b,
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [7:0]              wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic      [31:0]             wb_dat_o,
    output logic                         wb_ack_o,
    input  wire logic                    frame_tick,
    input  wire heit_pkg::heit_evt_s     nak_evt,
    input  wire heit_pkg::heit_evt_s     ok_evt,
    output logic      [NUM_EP:1]         poll_req,
    output logic      [NUM_EP:1]         ep_halt,
    output heit_pkg::heit_type_s [NUM_EP:1] rx_endpoint_type,
    output logic                         irq
);
    import heit_pkg::*;

    logic [7:0]       tx_endpoint_poll_interval [NUM_EP:1];
    logic [7:0]       interval_nxt [NUM_EP:1];
    heit_type_s       tx_mode_r [NUM_EP:1];
    heit_type_s       tx_mode_nxt [NUM_EP:1];
    heit_type_s       rx_type_nxt [NUM_EP:1];
    logic [15:0]      status_r;
    logic [15:0]      status_nxt;
    logic [15:0]      mask_r;
    logic [15:0]      mask_nxt;
    logic [15:0]      tmo_set;
    logic             irq_nxt;
    logic             ack_nxt;
    logic [31:0]      dat_nxt;
    logic             req;
    logic             wr;
    logic [3:0]       slot;
    logic [1:0]       word;
    logic [NUM_EP:1]  tmo_w;
    logic [NUM_EP:1]  poll_w;

    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = req && wb_we_i;
    assign slot = wb_adr_i[`HEIT_SLOT_MSB:`HEIT_SLOT_LSB];
    assign word = wb_adr_i[`HEIT_WORD_MSB:`HEIT_WORD_LSB];

    genvar g;
    generate
        for (g = 1; g <= NUM_EP; g++) begin : gen_ep
            heit_ep_sched u_sched (
                .clk_sys               (clk_sys),
                .rst_b                 (rst_b),
                .interval_or_nak_limit (tx_endpoint_poll_interval[g]),
                .tx_mode               (tx_mode_r[g]),
                .halt                  (status_r[g]),
                .frame_tick            (frame_tick),
                .nak_seen              (nak_evt.valid
                                        && nak_evt.ep == 4'(g)),
                .xfer_ok               (ok_evt.valid && ok_evt.ep == 4'(g)),
                .poll_r                (poll_w[g]),
                .tmo_r                 (tmo_w[g])
            );

            chk_halt_set: assert property (@(posedge clk_sys)
                disable iff (!rst_b) tmo_w[g] |=> ep_halt[g])
                else $error("nak timeout did not halt endpoint");
            chk_halt_poll: assert property (@(posedge clk_sys)
                disable iff (!rst_b) ep_halt[g] [*3]
                |-> !poll_req[g])
                else $error("halted endpoint still polled");
        end
    endgenerate

    always_comb begin
        tmo_set = '0;
        for (int i = 1; i <= NUM_EP; i++) begin
            tmo_set[i] = tmo_w[i];
        end
    end

    always_comb begin
        for (int i = 1; i <= NUM_EP; i++) begin
            interval_nxt[i] = tx_endpoint_poll_interval[i];
            tx_mode_nxt[i] = tx_mode_r[i];
            rx_type_nxt[i] = rx_endpoint_type[i];
            if (wr && wb_sel_i[0] && slot == 4'(i)) begin
                case (word)
                    `HEIT_OFS_INTERVAL: interval_nxt[i] = wb_dat_i[7:0];
                    `HEIT_OFS_TXMODE: tx_mode_nxt[i] = wb_dat_i[7:0];
                    `HEIT_OFS_RXTYPE: begin
                        rx_type_nxt[i] = wb_dat_i[7:0];
                    end
                    default: begin
                        interval_nxt[i] = tx_endpoint_poll_interval[i];
                    end
                endcase
            end
        end
    end

    always_comb begin
        mask_nxt = mask_r;
        status_nxt = status_r;
        if (wr && slot == 4'h0 && word == `HEIT_OFS_MASK) begin
            if (wb_sel_i[0]) mask_nxt[7:0] = wb_dat_i[7:0];
            if (wb_sel_i[1]) mask_nxt[15:8] = wb_dat_i[15:8];
        end
        if (wr && slot == 4'h0 && word == `HEIT_OFS_STATUS) begin
            if (wb_sel_i[0]) status_nxt[7:0] = status_r[7:0] & ~wb_dat_i[7:0];
            if (wb_sel_i[1]) begin
                status_nxt[15:8] = status_r[15:8] & ~wb_dat_i[15:8];
            end
        end
        // a timeout in the clearing cycle keeps the bit set
        status_nxt = status_nxt | tmo_set;
        irq_nxt = |(status_r & mask_r);
    end

    always_comb begin
        ack_nxt = req;
        dat_nxt = '0;
        if (req && !wb_we_i) begin
            if (slot == 4'h0) begin
                case (word)
                    `HEIT_OFS_STATUS: dat_nxt = {16'h0000, status_r};
                    `HEIT_OFS_MASK: dat_nxt = {16'h0000, mask_r};
                    default: dat_nxt = '0;
                endcase
            end else begin
                for (int i = 1; i <= NUM_EP; i++) begin
                    if (slot == 4'(i)) begin
                        case (word)
                            `HEIT_OFS_INTERVAL: begin
                                dat_nxt[7:0] = tx_endpoint_poll_interval[i];
                            end
                            `HEIT_OFS_TXMODE: dat_nxt[7:0] = tx_mode_r[i];
                            `HEIT_OFS_RXTYPE: begin
                                dat_nxt[7:0] = rx_endpoint_type[i];
                            end
                            default: dat_nxt = '0;
                        endcase
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 1; i <= NUM_EP; i++) begin
                tx_endpoint_poll_interval[i] <= `HEIT_RST_INTERVAL;
                tx_mode_r[i] <= `HEIT_RST_TYPE;
                rx_endpoint_type[i] <= `HEIT_RST_TYPE;
            end
            status_r <= `HEIT_RST_STATUS;
            mask_r <= `HEIT_RST_MASK;
            irq <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
            poll_req <= '0;
        end else begin
            for (int i = 1; i <= NUM_EP; i++) begin
                tx_endpoint_poll_interval[i] <= interval_nxt[i];
                tx_mode_r[i] <= tx_mode_nxt[i];
                rx_endpoint_type[i] <= rx_type_nxt[i];
            end
            status_r <= status_nxt;
            mask_r <= mask_nxt;
            irq <= irq_nxt;
            wb_ack_o <= ack_nxt;
            wb_dat_o <= dat_nxt;
            poll_req <= poll_w;
        end
    end

    always_comb begin
        ep_halt = status_r[NUM_EP:1];
    end

    chk_rxtype_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr && wb_sel_i[0] && slot == 4'h1 && word == `HEIT_OFS_RXTYPE)
        |=> rx_endpoint_type[1] == $past(wb_dat_i[7:0]))
        else $error("rx type write not stored");
    chk_wb_ack: assert property (@(posedge clk_sys) disable iff (!rst_b)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    chk_irq_level: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (|(status_r & mask_r)) |=> irq)
        else $error("interrupt not raised for unmasked status");
    chk_irq_low: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !(|(status_r & mask_r)) |=> !irq)
        else $error("interrupt raised with no unmasked status");

endmodule

// >>> heit_tgt_model.sv
/*
 * Target device model: NAKs a bulk endpoint once per frame while told to,
 * answers polls and the end of a NAK stream with one good handshake per cycle.
 * Assumes frame_tick and poll_req come from clk_sys logic.
 */
`timescale 1ns/1ps
module heit_tgt_model #(
    parameter int NUM_EP = 4
) (
    input  wire logic            clk_sys,
    input  wire logic            rst_b,
    input  wire logic [NUM_EP:1] poll_req,
    input  wire logic            frame_tick,
    input  wire logic            nak_on,
    input  wire logic [3:0]      nak_ep,
    output heit_pkg::heit_evt_s  nak_evt,
    output heit_pkg::heit_evt_s  ok_evt
);
    import heit_pkg::*;
    logic       nak_on_r;
    logic [3:0] ok_ep;
    // endpoint of the good handshake; end of a nak stream wins
    always_comb begin
        ok_ep = ~ok_evt.ep;
        for (int i = 1; i <= NUM_EP; i++) begin
            if (poll_req[i]) begin
                ok_ep = 4'(i);
            end
        end
        if (nak_on_r && !nak_on) begin
            ok_ep = nak_ep;
        end
    end
    // idle endpoint fields toggle so no stale value looks valid
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            nak_evt  <= '0;
            ok_evt   <= '0;
            nak_on_r <= 1'b0;
        end else begin
            nak_on_r      <= nak_on;
            nak_evt.valid <= nak_on && frame_tick;
            nak_evt.ep    <= (nak_on && frame_tick) ? nak_ep : ~nak_evt.ep;
            ok_evt.valid  <= (nak_on_r && !nak_on) || (|poll_req);
            ok_evt.ep     <= ok_ep;
        end
    end
endmodule

// >>> testbench.sv
/*
 * Self-checking bench for heit_top: registers, polling and bulk timeout.
 * Assumes heit_pkg and heit_tgt_model are compiled before it.
 */
`timescale 1ns/1ps
module testbench;
    import heit_pkg::*;
    logic              clk_sys = 1'b0;
    logic              rst_b = 1'b0;
    logic              wb_cyc_i = 1'b0;
    logic              wb_stb_i = 1'b0;
    logic              wb_we_i = 1'b0;
    logic [7:0]        wb_adr_i = 8'h00;
    logic [3:0]        wb_sel_i = 4'hF;
    logic [31:0]       wb_dat_i = 32'h0;
    logic [31:0]       wb_dat_o;
    logic              wb_ack_o;
    logic              frame_tick = 1'b0;
    heit_evt_s         nak_evt;
    heit_evt_s         ok_evt;
    logic [4:1]        poll_req;
    logic [4:1]        ep_halt;
    heit_type_s [4:1]  rx_endpoint_type;
    logic              irq;
    logic              nak_on = 1'b0;
    logic [3:0]        nak_ep = 4'h2;
    logic [31:0]       lfsr = 32'hDB37;
    logic [31:0]       exp_q[$];
    logic [31:0]       gap_q[$];
    logic [7:0]        pm_mode[4] = '{8'hB1, 8'h71, 8'h91, 8'hF1};
    int                pm_m[4] = '{3, 3, 2, 5};
    int                pm_gap[4] = '{3, 4, 2, 5};
    int                n_errors = 0;
    int                total_checks = 0;
    int                tick_cnt = 0;
    int                last_tick = -1;
    int                phase = 0;
    int                t0;

    heit_top #(.NUM_EP(4)) i_heit_top (.clk_sys(clk_sys), .rst_b(rst_b),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .frame_tick(frame_tick),
        .nak_evt(nak_evt), .ok_evt(ok_evt), .poll_req(poll_req),
        .ep_halt(ep_halt), .rx_endpoint_type(rx_endpoint_type), .irq(irq));

    heit_tgt_model #(.NUM_EP(4)) i_heit_tgt_model (.clk_sys(clk_sys),
        .rst_b(rst_b), .poll_req(poll_req), .frame_tick(frame_tick),
        .nak_on(nak_on), .nak_ep(nak_ep), .nak_evt(nak_evt),
        .ok_evt(ok_evt));

    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask

    // classic single cycle, held until ack is sampled high
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_errors++;
            $display("CHECK FAILED t=%0t no ack", $time);
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask

    task automatic cyc_wait(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic wait_tick(input int t);
        while (tick_cnt < t)
            @(posedge clk_sys);
    endtask

    // frame time base: one tick every 4 clocks
    always @(posedge clk_sys) begin
        phase <= (phase + 1) % 4;
        frame_tick <= (phase == 3);
        if (phase == 3)
            tick_cnt <= tick_cnt + 1;
    end

    // result monitor: oldest note per read data and per poll spacing
    always @(posedge clk_sys) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
            check(wb_dat_o, exp_q.pop_front(), "read data");
        if (poll_req[1] === 1'b1) begin
            if (last_tick >= 0 && gap_q.size() > 0)
                check(32'(tick_cnt - last_tick), gap_q.pop_front(), "gap");
            last_tick = tick_cnt;
        end
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        stop_test();
    end

    initial begin
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        cyc_wait(2);
        rd(8'h18, 32'h0);
        rd(8'h04, 32'h0);
        wr(8'h50, 32'hFF);
        rd(8'h50, 32'h0);
        for (int ep = 1; ep <= 4; ep++) begin
            lfsr = lfsr_next(lfsr);
            wr(8'(ep * 16), lfsr);
            rd(8'(ep * 16), {24'h0, lfsr[7:0]});
        end
        $display("test registers done");
        for (int c = 0; c < 16; c++) begin
            lfsr = lfsr_next(lfsr);
            t0 = int'(lfsr[5:4]) + 1;
            wr(8'(t0 * 16 + 8), {lfsr[31:8], c[3:0], lfsr[3:0]});
            check(32'(rx_endpoint_type[t0]), {c[3:0], lfsr[3:0]},
                  "rx type port");
            rd(8'(t0 * 16 + 8), {c[3:0], lfsr[3:0]});
        end
        $display("test rx type done");
        for (int k = 0; k < 4; k++) begin
            wr(8'h10, 32'h0);
            cyc_wait(12);
            last_tick = -1;
            wr(8'h14, 32'(pm_mode[k]));
            wr(8'h10, 32'(pm_m[k]));
            gap_q.push_back(pm_gap[k]);
            gap_q.push_back(pm_gap[k]);
            while (gap_q.size() > 0)
                @(posedge clk_sys);
        end
        wr(8'h10, 32'h0);
        $display("test polling done");
        wr(8'h04, 32'h4);
        wr(8'h24, 32'hA2);
        wr(8'h20, 32'h3);
        nak_on <= 1'b1;
        do @(posedge clk_sys);
        while (nak_evt.valid !== 1'b1);
        t0 = tick_cnt;
        wait_tick(t0 + 4);
        cyc_wait(3);
        check(32'(ep_halt[2]), 32'h0, "early halt");
        wait_tick(t0 + 5);
        cyc_wait(5);
        check(32'(ep_halt[2]), 32'h1, "halt");
        check(32'(irq), 32'h1, "irq set");
        rd(8'h00, 32'h4);
        wr(8'h04, 32'h0);
        cyc_wait(2);
        check(32'(irq), 32'h0, "irq masked");
        wr(8'h04, 32'h4);
        nak_on <= 1'b0;
        wr(8'h00, 32'h4);
        cyc_wait(2);
        check(32'({ep_halt[2], irq}), 32'h0, "cleared");
        $display("test bulk timeout done");
        for (int m = 0; m < 2; m++) begin
            wr(8'h20, 32'(m));
            nak_on <= 1'b1;
            cyc_wait(80);
            check(32'(ep_halt[2]), 32'h0, "no timeout");
            rd(8'h00, 32'h0);
            nak_on <= 1'b0;
            cyc_wait(4);
        end
        $display("test timeout disabled done");
        stop_test();
    end
endmodule
